// [core/amcr_pkg.sv]
// package: register map, field layout and decode types for the mode/trim registers
`default_nettype none
package amcr_pkg;
   localparam int          AddrWidth          = 15;
   localparam logic [14:0] AddrOperatingModeOne = 15'h0012;
   localparam logic [14:0] AddrOperatingModeTwo = 15'h0013;
   localparam logic [14:0] AddrInputImbalanceTrim = 15'h0014;
   localparam logic [7:0]  ResetModeOne       = 8'hC1;
   localparam logic [7:0]  ResetModeTwo       = 8'h20;
   localparam logic [7:0]  ResetTrim          = 8'h00;
   // field positions
   localparam int          FormatBit          = 7;
   localparam int          CommonModeLsb      = 5;
   localparam int          GateBit            = 2;
   localparam int          DividerLsb         = 0;
   localparam int          AmplitudeLsb       = 4;
   localparam int          PhaseLsb           = 0;
   // field encodings
   localparam logic [1:0]  DivideByOne        = 2'h0;
   localparam logic [1:0]  DivideByTwo        = 2'h1;
   localparam logic [1:0]  DivideByFour       = 2'h2;
   localparam logic [2:0]  AmplitudeReserved  = 3'h4;
   localparam logic [3:0]  PhaseReserved      = 4'h8;

   typedef struct packed {
      logic       writeStrobe;
      logic [14:0] address;
      logic [7:0] writeData;
   } amcr_access_type;

   typedef struct packed {
      logic       twosComplement;
      logic [1:0] commonModeSel;
      logic       gateOn;
      logic [2:0] divideRatio;  // 1, 2 or 4; 0 on reserved code
      logic [2:0] posLegTermSteps;
      logic [2:0] negLegTermSteps;
      logic [2:0] posLegCapSteps;
      logic [2:0] negLegCapSteps;
   } amcr_controls_type;

   typedef struct packed {
      logic [7:0]        modeOne;
      logic [7:0]        modeTwo;
      logic [7:0]        trim;
      logic [7:0]        readData;
      logic              syncRefDetect;
      amcr_controls_type controls;
   } amcr_state_type;
endpackage
`default_nettype wire

// [core/amcr_mode_config_regs.sv]
// module: operational-mode and imbalance-trim register slice with decoded controls
//
// Summary of operation
// [RL1] format bit 0 gives offset binary, 1 gives two's complement; resets to 1.
// [RL2] two-bit common-mode field picks one of four ranges, low to high; resets to 10.
// [RL3] host programs common-mode field to match a DC-coupled sync reference.
// [RL4] gate bit 0 (reset) ignores sync reference; 1 passes it to detection.
// [RL5] divider field: 00 divides by 1, 01 by 2, 10 by 4; 11 reserved.
// [RL6] host always writes 00 into bits 4:3 of mode register one.
// [RL7] host always writes 01 into bits 1:0 of mode register one.
// [RL8] host writes 001000 into bits 7:2 of mode register two.
// [RL9] mode register one sits at 0x0012 and reads 0xC1 after reset.
// [RL10] mode register two sits at 0x0013 and reads 0x20 after reset.
// [RL11] trim register at 0x0014 resets to 0x00: reserved bit, amplitude, phase.
// [RL12] amplitude codes 5-7 favour positive leg, 1-3 negative, 4 reserved, 0 neutral.
// [RL13] phase codes 1-7 load positive leg, 9-15 negative, 8 reserved, 0 none.
`default_nettype none
module amcr_mode_config_regs
   import amcr_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              nrst,
   input  wire amcr_access_type   access,
   input  wire logic              syncRefIn,
   output var  logic [7:0]        readData,
   output var  logic              syncRefDetect,
   output var  amcr_controls_type controls
);
   amcr_state_type state_reg;
   amcr_state_type state_next;

   // next-state block: register writes, read mux and control decode
   // everything sits in one struct so each output below is a plain flip-flop tap
   always_comb begin
      logic [7:0] one;
      logic [7:0] two;
      logic [7:0] trm;
      logic [2:0] amp;
      logic [3:0] ph;
      logic       hitOne;
      logic       hitTwo;
      logic       hitTrim;
      one = state_reg.modeOne;
      two = state_reg.modeTwo;
      trm = state_reg.trim;
      amp = 3'h0;
      ph = 4'h0;
      hitOne = 1'b0;
      hitTwo = 1'b0;
      hitTrim = 1'b0;
      state_next = state_reg;

      // address decode, shared by the write path and the read mux
      case (access.address)
         AddrOperatingModeOne: begin
            hitOne = 1'b1;
         end
         AddrOperatingModeTwo: begin
            hitTwo = 1'b1;
         end
         AddrInputImbalanceTrim: begin
            hitTrim = 1'b1;
         end
         default: begin
            hitOne = 1'b0;
         end
      endcase

      // writes: the host owns reserved-bit values, so all eight bits are stored
      // as written; forcing them here would hide host mistakes from read-back
      if (access.writeStrobe && hitOne) begin
         one = access.writeData; // RL9
      end
      if (access.writeStrobe && hitTwo) begin
         two = access.writeData; // RL10
      end
      if (access.writeStrobe && hitTrim) begin
         trm = access.writeData; // RL11
      end
      state_next.modeOne = one;
      state_next.modeTwo = two;
      state_next.trim = trm;

      // read mux: the byte shown next cycle already carries a same-edge write
      // unmapped addresses read as zero so a stray address is easy to spot
      if (hitOne) begin
         state_next.readData = one;
      end else if (hitTwo) begin
         state_next.readData = two;
      end else if (hitTrim) begin
         state_next.readData = trm;
      end else begin
         state_next.readData = 8'h00;
      end

      // mode register one fields
      state_next.controls.twosComplement = one[FormatBit]; // RL1
      state_next.controls.commonModeSel = one[CommonModeLsb +: 2]; // RL2
      state_next.controls.gateOn = one[GateBit]; // RL4

      // gate closed means the input never reaches detection
      state_next.syncRefDetect = one[GateBit] & syncRefIn; // RL4

      // divider: the reserved code gives ratio 0, holding the sample clock off
      // rather than guessing a ratio the converter was never meant to run at
      case (two[DividerLsb +: 2])
         DivideByOne: begin
            state_next.controls.divideRatio = 3'h1; // RL5
         end
         DivideByTwo: begin
            state_next.controls.divideRatio = 3'h2;
         end
         DivideByFour: begin
            state_next.controls.divideRatio = 3'h4;
         end
         default: begin
            state_next.controls.divideRatio = 3'h0;
         end
      endcase

      // amplitude trim: termination steps on one leg only, the other leg held at zero
      amp = trm[AmplitudeLsb +: 3];
      case (amp)
         3'h1: begin
            state_next.controls.posLegTermSteps = 3'h0;
            state_next.controls.negLegTermSteps = 3'h1; // RL12
         end
         3'h2: begin
            state_next.controls.posLegTermSteps = 3'h0;
            state_next.controls.negLegTermSteps = 3'h2;
         end
         3'h3: begin
            state_next.controls.posLegTermSteps = 3'h0;
            state_next.controls.negLegTermSteps = 3'h3;
         end
         AmplitudeReserved: begin
            // reserved code behaves as neutral so a bad write cannot skew the input
            state_next.controls.posLegTermSteps = 3'h0;
            state_next.controls.negLegTermSteps = 3'h0;
         end
         3'h5: begin
            state_next.controls.posLegTermSteps = 3'h1;
            state_next.controls.negLegTermSteps = 3'h0;
         end
         3'h6: begin
            state_next.controls.posLegTermSteps = 3'h2;
            state_next.controls.negLegTermSteps = 3'h0;
         end
         3'h7: begin
            state_next.controls.posLegTermSteps = 3'h3;
            state_next.controls.negLegTermSteps = 3'h0;
         end
         default: begin
            state_next.controls.posLegTermSteps = 3'h0;
            state_next.controls.negLegTermSteps = 3'h0;
         end
      endcase

      // phase trim: capacitive load on one leg only, never both at once
      ph = trm[PhaseLsb +: 4];
      case (ph)
         4'h1: begin
            state_next.controls.posLegCapSteps = 3'h1; // RL13
            state_next.controls.negLegCapSteps = 3'h0;
         end
         4'h2: begin
            state_next.controls.posLegCapSteps = 3'h2;
            state_next.controls.negLegCapSteps = 3'h0;
         end
         4'h3: begin
            state_next.controls.posLegCapSteps = 3'h3;
            state_next.controls.negLegCapSteps = 3'h0;
         end
         4'h4: begin
            state_next.controls.posLegCapSteps = 3'h4;
            state_next.controls.negLegCapSteps = 3'h0;
         end
         4'h5: begin
            state_next.controls.posLegCapSteps = 3'h5;
            state_next.controls.negLegCapSteps = 3'h0;
         end
         4'h6: begin
            state_next.controls.posLegCapSteps = 3'h6;
            state_next.controls.negLegCapSteps = 3'h0;
         end
         4'h7: begin
            state_next.controls.posLegCapSteps = 3'h7;
            state_next.controls.negLegCapSteps = 3'h0;
         end
         PhaseReserved: begin
            // reserved code adds no load on either leg
            state_next.controls.posLegCapSteps = 3'h0;
            state_next.controls.negLegCapSteps = 3'h0;
         end
         4'h9: begin
            state_next.controls.posLegCapSteps = 3'h0;
            state_next.controls.negLegCapSteps = 3'h1;
         end
         4'hA: begin
            state_next.controls.posLegCapSteps = 3'h0;
            state_next.controls.negLegCapSteps = 3'h2;
         end
         4'hB: begin
            state_next.controls.posLegCapSteps = 3'h0;
            state_next.controls.negLegCapSteps = 3'h3;
         end
         4'hC: begin
            state_next.controls.posLegCapSteps = 3'h0;
            state_next.controls.negLegCapSteps = 3'h4;
         end
         4'hD: begin
            state_next.controls.posLegCapSteps = 3'h0;
            state_next.controls.negLegCapSteps = 3'h5;
         end
         4'hE: begin
            state_next.controls.posLegCapSteps = 3'h0;
            state_next.controls.negLegCapSteps = 3'h6;
         end
         4'hF: begin
            state_next.controls.posLegCapSteps = 3'h0;
            state_next.controls.negLegCapSteps = 3'h7;
         end
         default: begin
            state_next.controls.posLegCapSteps = 3'h0;
            state_next.controls.negLegCapSteps = 3'h0;
         end
      endcase
   end

   // synchronous active-low reset to printed values
   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_reg <= '0;
         state_reg.modeOne <= ResetModeOne; // RL9
         state_reg.modeTwo <= ResetModeTwo; // RL10
         state_reg.trim <= ResetTrim; // RL11
         state_reg.controls.twosComplement <= ResetModeOne[FormatBit];
         state_reg.controls.commonModeSel <= ResetModeOne[CommonModeLsb +: 2];
         state_reg.controls.divideRatio <= 3'h1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign readData = state_reg.readData;
   assign syncRefDetect = state_reg.syncRefDetect;
   assign controls = state_reg.controls;
endmodule
`default_nettype wire

// [test/amcr_props.sv]
// checker: write-to-control timing of the mode and trim register slice
`default_nettype none
module amcr_props
   import amcr_pkg::*;
(
   input wire logic              clock,
   input wire logic              nrst,
   input wire amcr_access_type   access,
   input wire logic              syncRefIn,
   input wire logic [7:0]        readData,
   input wire logic              syncRefDetect,
   input wire amcr_controls_type controls
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   wire logic [7:0] d = access.writeData;
   sequence w(logic [14:0] a); access.writeStrobe && access.address == a; endsequence
   property p_fmt; w(15'h0012) |=> controls.twosComplement == $past(d[7]); endproperty
   a_fmt: assert property (p_fmt) else $error("format bit wrong");
   property p_cm; w(15'h0012) |=> controls.commonModeSel == $past(d[6:5]); endproperty
   a_cm: assert property (p_cm) else $error("common mode wrong");
   property p_gate; $stable(controls.gateOn) |-> syncRefDetect == ($past(syncRefIn) && controls.gateOn); endproperty
   a_gate: assert property (p_gate) else $error("gate wrong");
   property p_div; w(15'h0013) |=> controls.divideRatio == ($past(d[1:0]) == 2'h3 ? 3'h0 : 3'h1 << $past(d[1:0])); endproperty
   a_div: assert property (p_div) else $error("divider wrong");
   property p_amp; w(15'h0014) |=> {controls.posLegTermSteps, controls.negLegTermSteps} ==
      ($past(d[6]) ? {1'b0, $past(d[5:4]), 3'h0} : {3'h0, $past(d[6:4])}); endproperty
   a_amp: assert property (p_amp) else $error("amplitude wrong");
   property p_ph; w(15'h0014) |=> {controls.posLegCapSteps, controls.negLegCapSteps} ==
      ($past(d[3]) ? {3'h0, $past(d[2:0])} : {$past(d[2:0]), 3'h0}); endproperty
   a_ph: assert property (p_ph) else $error("phase wrong");
   property p_unm; !(access.address inside {[15'h0012:15'h0014]}) |=> readData == 8'h00; endproperty
   a_unm: assert property (p_unm) else $error("unmapped read");
   property p_hold; !access.writeStrobe |=> $stable(controls); endproperty
   a_hold: assert property (p_hold) else $error("controls moved");
   property p_rst;
      disable iff (1'b0) !nrst |=> readData == 8'h00 && !syncRefDetect && controls.twosComplement &&
         controls.commonModeSel == 2'h2 && !controls.gateOn && controls.divideRatio == 3'h1 &&
         controls.posLegTermSteps == 3'h0 && controls.negLegCapSteps == 3'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   property p_echo; w(15'h0013) |=> readData == $past(d); endproperty
   a_echo: assert property (p_echo) else $error("write not read back");
endmodule
bind amcr_mode_config_regs amcr_props amcr_props_i (.clock(clock), .nrst(nrst), .access(access),
   .syncRefIn(syncRefIn), .readData(readData), .syncRefDetect(syncRefDetect), .controls(controls));
`default_nettype wire

// [test/amcr_host_model.sv]
// host model: drives the configuration port one request per falling edge
`default_nettype none
module amcr_host_model
   import amcr_pkg::*;
(
   input  wire logic                 clock,
   output var  amcr_pkg::amcr_access_type access
);
   timeunit 1ns;
   timeprecision 1ps;
   initial access = '0;
   // reserved bits are forced here; reserved field codes such as divider 11 still reach the slice
   task automatic put(input logic [14:0] a, input logic [7:0] d, input logic w, output logic [7:0] s);
      s = a == 15'h0012 ? {d[7:5], 2'h0, d[2], 2'h1} : a == 15'h0013 ? {6'h08, d[1:0]} : {1'b0, d[6:0]};
      @(negedge clock);
      access <= '{w, a, w ? s : 8'h00};
   endtask
endmodule
`default_nettype wire

// [test/amcr_mode_config_regs_bench.sv]
// bench: reset values, field sweeps and a mid-run reset
`default_nettype none
module amcr_mode_config_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, nrst = 1'b0, syncRefIn = 1'b0, chkD = 1'b0;
   logic [7:0] readData, s, mirror [0:2], expQ [$];
   int badCount = 0, testsRun = 0, cycles = 0;
   amcr_pkg::amcr_access_type acc;
   amcr_pkg::amcr_controls_type controls, ctlQ [$];
   always #5 clock = ~clock;
   amcr_host_model amcr_host_model_i (.clock(clock), .access(acc));
   amcr_mode_config_regs amcr_mode_config_regs_i (.clock(clock), .nrst(nrst), .access(acc),
      .syncRefIn(syncRefIn), .readData(readData), .syncRefDetect(), .controls(controls));
   // expected decode of the three stored bytes, worked from the field tables
   function automatic amcr_pkg::amcr_controls_type expCtl(input logic [7:0] m1, input logic [7:0] m2,
      input logic [7:0] tr);
      amcr_pkg::amcr_controls_type c;
      c = '0;
      c.twosComplement = m1[7];
      c.commonModeSel = m1[6:5];
      c.gateOn = m1[2];
      c.divideRatio = m2[1:0] == 2'h0 ? 3'h1 : m2[1:0] == 2'h1 ? 3'h2 : m2[1:0] == 2'h2 ? 3'h4 : 3'h0;
      if (tr[6:4] >= 3'h5) c.posLegTermSteps = tr[6:4] - 3'h4;
      if (tr[6:4] <= 3'h3) c.negLegTermSteps = tr[6:4];
      if (tr[3:0] >= 4'h9) c.negLegCapSteps = 3'(tr[3:0] - 4'h8);
      if (tr[3:0] <= 4'h7) c.posLegCapSteps = tr[2:0];
      return c;
   endfunction
   // reads note what the mirror of really-sent data predicts; unmapped reads give zero
   task automatic op(input int a, input logic [7:0] d, input logic w);
      amcr_host_model_i.put(15'(a), d, w, s);
      if (w && a inside {[18:20]}) mirror[a - 18] = s;
      if (!w) expQ.push_back(a inside {[18:20]} ? mirror[a - 18] : 8'h00);
      if (!w) ctlQ.push_back(expCtl(mirror[0], mirror[1], mirror[2]));
   endtask
   task automatic chkCtl(input amcr_pkg::amcr_controls_type e);
      testsRun++;
      if (controls !== e) badCount++;
      if (controls !== e) $display("ERROR %0t controls %h expected %h", $time, controls, e);
   endtask
   task automatic chk(input logic [7:0] e);
      testsRun++;
      if (readData !== e) badCount++;
      if (readData !== e) $display("ERROR %0t read %h expected %h", $time, readData, e);
   endtask
   task automatic giveVerdict;
      $display("compares %0d mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // watcher: data lands one edge after the address; runs past 1000 cycles count as a hang
   always @(posedge clock) chkD <= expQ.size() > 0;
   always @(negedge clock) begin
      syncRefIn <= 1'($urandom);
      cycles++;
      if (chkD) chk(expQ.pop_front());
      if (chkD) chkCtl(ctlQ.pop_front());
      if (cycles == 1000) badCount++;
      if (cycles == 1000) giveVerdict;
   end
   initial begin
      void'($urandom(32'h056A0B19));
      repeat (5) @(negedge clock);
      for (int r = 0; r < 2; r++) begin
         mirror = '{8'hC1, 8'h20, 8'h00};
         nrst = 1'b1;
         for (int i = 0; i < 128; i++) op(18 + i / 32, {4'($urandom), 4'(i / 2)}, i % 2 == 1);
         nrst = 1'b0;
         @(negedge clock);
         $display("round %0d done", r);
      end
      giveVerdict;
   end
endmodule
`default_nettype wire
